// ==== src/spx_pkg.sv ====
// Constants and types shared by the external SPI master controller.
// Assumes one 25 MHz clock and a byte-addressed Avalon-MM register window.
package spx_pkg;
    // ------------------------------------------------------------------
    // Register offsets (byte addresses, one aligned word each)
    // ------------------------------------------------------------------
    localparam logic [4:0] SPX_OFF_CTRL = 5'h00;
    localparam logic [4:0] SPX_OFF_TX = 5'h04;
    localparam logic [4:0] SPX_OFF_STATUS = 5'h08;
    localparam logic [4:0] SPX_OFF_RX = 5'h0C;

    // ------------------------------------------------------------------
    // Control register fields
    // ------------------------------------------------------------------
    localparam int SPX_CTRL_PHASE = 0;
    localparam int SPX_CTRL_POL = 1;
    localparam int SPX_CTRL_RATE_LO = 2;
    localparam int SPX_CTRL_RATE_HI = 4;
    localparam int SPX_CTRL_HOLD = 5;
    localparam int SPX_CTRL_RXONLY = 6;
    localparam logic [6:0] SPX_CTRL_RESET = 7'h00;

    // ------------------------------------------------------------------
    // Status register fields
    // ------------------------------------------------------------------
    localparam int SPX_STAT_BUSY = 0;
    localparam int SPX_STAT_DONE = 1;
    localparam int SPX_STAT_OVER = 2;
    localparam int SPX_STAT_REJECT = 3;
    localparam int SPX_STAT_SELECT = 4;

    // ------------------------------------------------------------------
    // Timing: SCK half period is SPX_HALF_BASE << rate clock cycles for rates 0 to 6; rate 7 wraps to 256
    // ------------------------------------------------------------------
    localparam logic [7:0] SPX_HALF_BASE = 8'h04; // Room for two MISO sync stages
    localparam logic [3:0] SPX_LAST_EDGE = 4'hF;
    localparam logic [7:0] SPX_DATA_RESET = 8'h00;

    typedef enum logic [2:0] {
        SPX_IDLE = 3'b000,
        SPX_LEAD = 3'b001,
        SPX_SHIFT = 3'b010,
        SPX_TAIL = 3'b011,
        SPX_GAP = 3'b100
    } spx_state_t;
endpackage

// ==== src/spx_tick_if.sv ====
// Carrier between the controller and its SCK half-period tick generator.
// Assumes both ends run on the same clock.
`timescale 1ns/1ns
`default_nettype none
interface spx_tick_if;
    logic run;
    logic [7:0] half_cycles;
    logic tick;
    modport gen (input run, input half_cycles, output tick);
    modport user (output run, output half_cycles, input tick);
endinterface
`default_nettype wire

// ==== src/spx_tick_gen.sv ====
// Half-period tick divider for the serial clock.
// Assumes half_cycles is stable while run is high and at least 2.
`timescale 1ns/1ns
`default_nettype none
module spx_tick_gen
    import spx_pkg::*;
(
    input wire logic clk,      // System clock
    input wire logic reset_n,  // Synchronous reset, active low
    spx_tick_if.gen tk         // Run request and tick pulse
);
    logic [7:0] cnt_reg;

    // ------------------------------------------------------------------
    // Divider
    // ------------------------------------------------------------------
    // Counter restarts when run drops so the first half period is whole
    always_ff @(posedge clk) begin
        if (!reset_n || !tk.run) begin
            cnt_reg <= 8'h00;
        end else if (cnt_reg == tk.half_cycles - 8'h01) begin
            cnt_reg <= 8'h00;
        end else begin
            cnt_reg <= cnt_reg + 8'h01;
        end
    end

    // One-cycle enable pulse at the end of each half period
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            tk.tick <= 1'b0;
        end else begin
            tk.tick <= tk.run && (cnt_reg == tk.half_cycles - 8'h01);
        end
    end
endmodule
`default_nettype wire

// ==== src/spx_master.sv ====
// External SPI master that drives a byte-wide SPI port in its slave role.
// Assumes software on an Avalon-MM bus; the target's select pin is ss_n_out.
//
// The address map and the Avalon-MM register port were left to the implementer.
`timescale 1ns/1ns
`default_nettype none
// How it works
// - Bytes shift most significant bit first
// - Only we start transfers and drive SCK
// - Tied data lines: one direction at a time
// - Both ends use the same polarity/phase
// - A master keeps internal select high
// - Phase 1: select low whole transmission; here only with the hold bit set, else released per byte
// - Phase 0: select low per byte, high between
// - Never clock target faster than its clock/2
// - Master setup order: rate, select, enable
// - Select setup precedes master select bit
// - Slave setup: mode, select, then enable
// - Clear done before next byte ends
// - Polarity and phase pick sampling edge
module spx_master
    import spx_pkg::*;
(
    input wire logic clk,                  // System clock, 25 MHz
    input wire logic reset_n,              // Synchronous reset, active low
    input wire logic [4:0] avs_address,    // Byte address
    input wire logic avs_read,             // Read request
    input wire logic avs_write,            // Write request
    input wire logic [3:0] avs_byteenable, // Byte lanes
    input wire logic [31:0] avs_writedata, // Write data
    output logic [31:0] avs_readdata,      // Read data, registered
    output logic avs_waitrequest,          // Stall, low on answer cycle
    output logic sck_out,                  // Serial clock to target
    output logic mosi_out,                 // Serial data to target
    output logic mosi_oe,                  // Drive enable for data out
    input wire logic miso_in,              // Serial data from target
    output logic ss_n_out                  // Target select, active low
);
    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    spx_tick_if tk ();
    spx_state_t state_reg;
    logic ack_reg;
    logic [6:0] ctrl_reg;
    logic [7:0] tx_sh_reg;
    logic [7:0] rx_sh_reg;
    logic [7:0] rx_data_reg;
    logic [3:0] edge_reg;
    logic done_reg;
    logic over_reg;
    logic reject_reg;
    logic miso_meta_reg;
    logic miso_s_reg;
    logic sck_reg;
    logic mosi_reg;
    logic mosi_oe_reg;
    logic ss_n_reg;
    logic take;
    logic wr_ctrl;
    logic wr_tx;
    logic rd_status;
    logic rd_rx;
    logic start;
    logic tick;
    logic leading;
    logic last_edge;
    logic phase;
    logic finish;
    logic [2:0] rate;

    // ------------------------------------------------------------------
    // Avalon slave handshake
    // ------------------------------------------------------------------
    // Every access waits one cycle so read data can come from a flop
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            ack_reg <= 1'b0;
        end else begin
            ack_reg <= (avs_read || avs_write) && !ack_reg;
        end
    end

    assign avs_waitrequest = (avs_read || avs_write) && !ack_reg;
    assign take = ack_reg && (avs_read || avs_write);

    // Address decode on the accepting edge; only lane 0 carries fields
    always_comb begin
        wr_ctrl = 1'b0;
        wr_tx = 1'b0;
        rd_status = 1'b0;
        rd_rx = 1'b0;
        if (take && avs_write && avs_byteenable[0] && avs_address == SPX_OFF_CTRL) begin
            wr_ctrl = 1'b1;
        end else if (take && avs_write && avs_byteenable[0] && avs_address == SPX_OFF_TX) begin
            wr_tx = 1'b1;
        end else if (take && avs_read && avs_address == SPX_OFF_STATUS) begin
            rd_status = 1'b1;
        end else if (take && avs_read && avs_address == SPX_OFF_RX) begin
            rd_rx = 1'b1;
        end
    end

    // Read data; unmapped offsets read as zero
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            avs_readdata <= 32'h0000_0000;
        end else if ((avs_read && !ack_reg) && avs_address == SPX_OFF_CTRL) begin
            avs_readdata <= {25'h000_0000, ctrl_reg};
        end else if ((avs_read && !ack_reg) && avs_address == SPX_OFF_STATUS) begin
            avs_readdata <= {27'h000_0000, ~ss_n_reg, reject_reg, over_reg, done_reg,
                             state_reg != SPX_IDLE};
        end else if ((avs_read && !ack_reg) && avs_address == SPX_OFF_RX) begin
            avs_readdata <= {24'h00_0000, rx_data_reg};
        end else if (avs_read && !ack_reg) begin
            avs_readdata <= 32'h0000_0000;
        end
    end

    // ------------------------------------------------------------------
    // Control register
    // ------------------------------------------------------------------
    // Mode bits must match the target's setup; software's job to agree
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            ctrl_reg <= SPX_CTRL_RESET;
        end else if (wr_ctrl) begin
            ctrl_reg <= avs_writedata[6:0];
        end
    end

    assign phase = ctrl_reg[SPX_CTRL_PHASE];
    assign rate = ctrl_reg[SPX_CTRL_RATE_HI:SPX_CTRL_RATE_LO];

    // ------------------------------------------------------------------
    // Status flags
    // ------------------------------------------------------------------
    assign start = wr_tx && state_reg == SPX_IDLE;
    assign finish = tick && state_reg == SPX_TAIL;

    // Done: set on byte end, cleared by reading received data; set wins
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            done_reg <= 1'b0;
        end else if (finish) begin
            done_reg <= 1'b1;
        end else if (rd_rx) begin
            done_reg <= 1'b0;
        end
    end

    // Overrun: byte ended with done still set; status read clears it
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            over_reg <= 1'b0;
        end else if (finish && done_reg && !rd_rx) begin
            over_reg <= 1'b1;
        end else if (rd_status) begin
            over_reg <= 1'b0;
        end
    end

    // Rejected write: data write while a byte is in flight is dropped
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            reject_reg <= 1'b0;
        end else if (wr_tx && state_reg != SPX_IDLE) begin
            reject_reg <= 1'b1;
        end else if (rd_status) begin
            reject_reg <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // MISO synchroniser
    // ------------------------------------------------------------------
    // Target drives MISO from its own clock, so two flops before use
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            miso_meta_reg <= 1'b0;
            miso_s_reg <= 1'b0;
        end else begin
            miso_meta_reg <= miso_in;
            miso_s_reg <= miso_meta_reg;
        end
    end

    // ------------------------------------------------------------------
    // SCK divider
    // ------------------------------------------------------------------
    // Smallest half period is four cycles: MISO spends two in its synchroniser
    assign tk.run = state_reg != SPX_IDLE;
    assign tk.half_cycles = SPX_HALF_BASE << rate;
    assign tick = tk.tick;

    spx_tick_gen u_tick (
        .clk(clk),
        .reset_n(reset_n),
        .tk(tk)
    );

    // ------------------------------------------------------------------
    // Transfer sequencer
    // ------------------------------------------------------------------
    assign leading = !edge_reg[0];
    assign last_edge = edge_reg == SPX_LAST_EDGE;

    // Lead half period, sixteen edges, tail half period, optional gap
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            state_reg <= SPX_IDLE;
        end else begin
            case (state_reg)
                SPX_IDLE: begin
                    if (start) begin
                        state_reg <= SPX_LEAD;
                    end
                end
                SPX_LEAD: begin
                    if (tick) begin
                        state_reg <= SPX_SHIFT;
                    end
                end
                SPX_SHIFT: begin
                    if (tick && last_edge) begin
                        state_reg <= SPX_TAIL;
                    end
                end
                SPX_TAIL: begin
                    if (tick && (!phase || !ctrl_reg[SPX_CTRL_HOLD])) begin
                        state_reg <= SPX_GAP;
                    end else if (tick) begin
                        state_reg <= SPX_IDLE;
                    end
                end
                SPX_GAP: begin
                    if (tick) begin
                        state_reg <= SPX_IDLE;
                    end
                end
                default: begin
                    state_reg <= SPX_IDLE;
                end
            endcase
        end
    end

    // Edge counter, cleared at every byte start
    always_ff @(posedge clk) begin
        if (!reset_n || start) begin
            edge_reg <= 4'h0;
        end else if (tick && state_reg == SPX_SHIFT) begin
            edge_reg <= edge_reg + 4'h1;
        end
    end

    // SCK toggles each half period of the shift and parks at the polarity level
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            sck_reg <= 1'b0;
        end else if (state_reg == SPX_IDLE) begin
            sck_reg <= ctrl_reg[SPX_CTRL_POL];
        end else if (tick && state_reg == SPX_SHIFT) begin
            sck_reg <= ~sck_reg;
        end
    end

    // Transmit shifter; phase 0 presents bit 7 before the first edge
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            tx_sh_reg <= SPX_DATA_RESET;
            mosi_reg <= 1'b0;
        end else if (start) begin
            tx_sh_reg <= avs_writedata[7:0];
            mosi_reg <= phase ? mosi_reg : avs_writedata[7];
        end else if (tick && state_reg == SPX_SHIFT && !phase && !leading && !last_edge) begin
            tx_sh_reg <= {tx_sh_reg[6:0], 1'b0};
            mosi_reg <= tx_sh_reg[6];
        end else if (tick && state_reg == SPX_SHIFT && phase && leading) begin
            tx_sh_reg <= {tx_sh_reg[6:0], 1'b0};
            mosi_reg <= tx_sh_reg[7];
        end
    end

    // Receive shifter samples on the edge the mode selects
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            rx_sh_reg <= SPX_DATA_RESET;
        end else if (tick && state_reg == SPX_SHIFT && (leading != phase)) begin
            rx_sh_reg <= {rx_sh_reg[6:0], miso_s_reg};
        end
    end

    // Received byte stands until the next byte ends
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            rx_data_reg <= SPX_DATA_RESET;
        end else if (finish) begin
            rx_data_reg <= rx_sh_reg;
        end
    end

    // Select: low from start; phase 0 always releases between bytes
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            ss_n_reg <= 1'b1;
        end else if (start) begin
            ss_n_reg <= 1'b0;
        end else if (finish && (!phase || !ctrl_reg[SPX_CTRL_HOLD])) begin
            ss_n_reg <= 1'b1;
        end else if (wr_ctrl && state_reg == SPX_IDLE && !avs_writedata[SPX_CTRL_HOLD]) begin
            ss_n_reg <= 1'b1;
        end
    end

    // Data drive while selected and for one cycle after release; receive-only for a shared line
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            mosi_oe_reg <= 1'b0;
        end else begin
            mosi_oe_reg <= (start || !ss_n_reg) && !ctrl_reg[SPX_CTRL_RXONLY];
        end
    end

    assign sck_out = sck_reg;
    assign mosi_out = mosi_reg;
    assign mosi_oe = mosi_oe_reg;
    assign ss_n_out = ss_n_reg;
endmodule
`default_nettype wire

// ==== verification/spx_master_properties.sv ====
// Port checker for the SPI master controller.
// Assumes one clock domain; bound to every spx_master.
`timescale 1ns/1ns
`default_nettype none
module spx_master_props
    import spx_pkg::*;
(
    input wire logic clk, // Clock
    input wire logic reset_n, // Reset, low
    input wire logic [4:0] avs_address, // Address
    input wire logic avs_read, // Read
    input wire logic avs_write, // Write
    input wire logic [3:0] avs_byteenable, // Lanes
    input wire logic [31:0] avs_writedata, // Wdata
    input wire logic [31:0] avs_readdata, // Rdata
    input wire logic avs_waitrequest, // Stall
    input wire logic sck_out, // SCK
    input wire logic mosi_out, // MOSI
    input wire logic mosi_oe, // MOSI enable
    input wire logic miso_in, // MISO
    input wire logic ss_n_out // Select
);
    // ------------
    // Helper logic
    // ------------
    logic [6:0] ctrl_reg;
    logic sck_prev_reg;
    logic [7:0] edges_reg;
    logic ctrl_wr;
    logic tx_wr;
    logic pha;
    assign ctrl_wr = avs_write && !avs_waitrequest && avs_byteenable[0]
        && avs_address == SPX_OFF_CTRL;
    assign tx_wr = avs_write && !avs_waitrequest && avs_byteenable[0]
        && avs_address == SPX_OFF_TX;
    assign pha = ctrl_reg[SPX_CTRL_PHASE];
    // Control mirror, since the register itself is hidden
    always_ff @(posedge clk) begin
        if (!reset_n) ctrl_reg <= SPX_CTRL_RESET;
        else if (ctrl_wr) ctrl_reg <= avs_writedata[6:0];
    end
    // SCK toggles inside one select window
    always_ff @(posedge clk) begin
        sck_prev_reg <= sck_out;
        if (!reset_n || ss_n_out) edges_reg <= 8'h00;
        else if (sck_out != sck_prev_reg) edges_reg <= edges_reg + 8'h01;
    end
    // ----------
    // Assertions
    // ----------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);
    AST_WAIT_ONE: assert property (
        (avs_read | avs_write) && avs_waitrequest |=> !avs_waitrequest) else $error("no answer");
    AST_SCK_IDLE: assert property (
        ss_n_out && $past(ss_n_out) && !$past(avs_write) && !$past(avs_write, 2)
        |-> $stable(sck_out)) else $error("sck moved while idle");
    AST_SCK_BYTE: assert property (
        $rose(ss_n_out) |-> edges_reg[3:0] == 4'h0 && edges_reg != 8'h00)
        else $error("partial byte");
    AST_SAMPLE_STABLE: assert property (
        $changed(sck_out) && !ss_n_out && ((sck_out != ctrl_reg[SPX_CTRL_POL]) != pha)
        |-> $stable(mosi_out)) else $error("mosi moved on capture edge");
    // Lead half period keeps the clock still after select
    AST_LEAD_HALF: assert property (
        $fell(ss_n_out) |-> $stable(sck_out) [*3]) else $error("no lead time");
    AST_BYTE_PHASE0: assert property (
        !ss_n_out && !pha |-> edges_reg <= 8'h10) else $error("select held past byte");
    AST_FALL_CAUSE: assert property (
        $fell(ss_n_out) |-> $past(tx_wr)) else $error("select without data write");
    AST_OE_DRIVE: assert property (
        !ss_n_out && !$past(ss_n_out) && !ctrl_reg[SPX_CTRL_RXONLY] |-> mosi_oe)
        else $error("mosi not driven");
    AST_OE_RXONLY: assert property (
        ctrl_reg[SPX_CTRL_RXONLY] && !$past(ctrl_wr) |-> !mosi_oe) else $error("mosi driven");
    COV_PHASE1: cover property ($fell(ss_n_out) && pha);
    COV_HOLD: cover property ($rose(ss_n_out) && edges_reg == 8'h20);
    COV_RXONLY: cover property (ctrl_reg[SPX_CTRL_RXONLY] && !ss_n_out);
endmodule
bind spx_master spx_master_props u_spx_master_props (.clk(clk), .reset_n(reset_n),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_byteenable(avs_byteenable), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .sck_out(sck_out),
    .mosi_out(mosi_out), .mosi_oe(mosi_oe), .miso_in(miso_in), .ss_n_out(ss_n_out));
`default_nettype wire

// ==== verification/spx_target_model.sv ====
// Behavioural model of the SPI port in its slave role.
// Assumes plain levels on select, clock and data.
`timescale 1ns/1ns
`default_nettype none
module spx_target_model (
    input wire logic ss_n, // Select, low
    input wire logic sck, // Clock in
    input wire logic mosi, // Data in
    input wire logic clock_polarity, // Polarity
    input wire logic clock_phase, // Phase
    input wire logic [7:0] load_byte, // Reply byte
    output logic miso, // Data out
    output logic [7:0] rx_byte, // Last byte in
    output logic [7:0] byte_count // Bytes done
);
    logic [7:0] tx_sh;
    logic [7:0] rx_sh;
    logic [3:0] nbits;
    initial begin
        miso = 1'b0;
        rx_byte = 8'h00;
        byte_count = 8'h00;
    end
    // Select fall; phase 0 shows the top bit at once
    always @(negedge ss_n) begin
        tx_sh = load_byte;
        nbits = 4'h0;
        if (!clock_phase) begin
            miso = tx_sh[7];
            tx_sh = {tx_sh[6:0], 1'b0};
        end
    end
    // Released line must not look like held data
    always @(posedge ss_n) miso = ~miso;
    // Clock is only ever an input here
    always @(sck) begin
        if (!ss_n && ((sck != clock_polarity) != clock_phase)) begin
            rx_sh = {rx_sh[6:0], mosi};
            nbits = nbits + 4'h1;
            if (nbits == 4'h8) begin
                rx_byte = rx_sh;
                byte_count = byte_count + 8'h01;
                nbits = 4'h0;
            end
        end else if (!ss_n) begin
            if (clock_phase && nbits == 4'h0) tx_sh = load_byte;
            miso = tx_sh[7];
            tx_sh = {tx_sh[6:0], 1'b0};
        end
    end
endmodule
`default_nettype wire

// ==== verification/tb.sv ====
// Bench: SPI master controller against a target model over Avalon-MM.
// Assumes design and checker files are compiled first.
`timescale 1ns/1ns
`default_nettype none
module tb
    import spx_pkg::*;
;
    logic clk;
    logic reset_n;
    logic [4:0] avs_address;
    logic avs_read;
    logic avs_write;
    logic [31:0] avs_writedata;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic sck_out, mosi_out, mosi_oe, miso_in, ss_n_out, mosi_line, t_pol, t_pha;
    logic [7:0] t_load, t_rx;
    logic [31:0] rd, st_acc;
    int err_count, checks;
    // Released data line shows the inverse of its last level
    assign mosi_line = mosi_oe ? mosi_out : ~mosi_out;
    spx_master u_spx_master (.clk(clk), .reset_n(reset_n), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_byteenable(4'hF),
        .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .sck_out(sck_out), .mosi_out(mosi_out),
        .mosi_oe(mosi_oe), .miso_in(miso_in), .ss_n_out(ss_n_out));
    spx_target_model u_spx_target_model (.ss_n(ss_n_out), .sck(sck_out), .mosi(mosi_line),
        .clock_polarity(t_pol), .clock_phase(t_pha), .load_byte(t_load), .miso(miso_in), .rx_byte(t_rx),
        .byte_count());
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    // -----
    // Tasks
    // -----
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // One access, held until waitrequest is seen low
    task automatic bus(input logic wr, input logic [4:0] addr, input logic [31:0] data);
        avs_address <= addr;
        avs_writedata <= data;
        avs_write <= wr;
        avs_read <= !wr;
        @(posedge clk);
        while (avs_waitrequest !== 1'b0) begin
            @(posedge clk);
        end
        check("answer", avs_waitrequest, 1'b0);
        rd = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        @(posedge clk);
    endtask
    task automatic rdchk(input string what, input logic [4:0] addr, input logic [31:0] exp);
        bus(1'b0, addr, 32'h0000_0000);
        check(what, rd, exp);
    endtask
    // Status polling clears sticky flags, so collect them
    task automatic wait_idle();
        int n = 0;
        st_acc = 32'h0000_0000;
        rd = 32'h0000_0001;
        while (rd[SPX_STAT_BUSY] !== 1'b0 && n < 1000) begin
            bus(1'b0, SPX_OFF_STATUS, 32'h0000_0000);
            st_acc = st_acc | rd;
            n++;
        end
        check("idle", rd[SPX_STAT_BUSY], 1'b0);
    endtask
    task automatic xfer(input logic [6:0] ctrl, input logic [7:0] tx, input logic [7:0] back);
        t_pol <= ctrl[SPX_CTRL_POL];
        t_pha <= ctrl[SPX_CTRL_PHASE];
        t_load <= back;
        bus(1'b1, SPX_OFF_CTRL, {25'h000_0000, ctrl});
        bus(1'b1, SPX_OFF_TX, {24'h00_0000, tx});
    endtask
    task automatic close_out();
        $display("checks %0d mismatches %0d", checks, err_count);
        if (err_count == 0 && checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    // Hang guard, well beyond the slowest rate
    initial begin
        repeat (60000) @(posedge clk);
        err_count++;
        $display("watchdog expired");
        close_out();
    end
    // -----
    // Tests
    // -----
    initial begin
        reset_n = 1'b0;
        avs_address = 5'h00;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h0000_0000;
        t_pol = 1'b0;
        t_pha = 1'b0;
        t_load = 8'h00;
        err_count = 0;
        checks = 0;
        repeat (20) @(posedge clk);
        reset_n <= 1'b1;
        @(posedge clk);
        rdchk("ctrl", SPX_OFF_CTRL, 32'h0000_0000);
        rdchk("status", SPX_OFF_STATUS, 32'h0000_0000);
        bus(1'b1, 5'h14, 32'h0000_00FF);
        rdchk("unmapped", 5'h14, 32'h0000_0000);
        rdchk("ctrl kept", SPX_OFF_CTRL, 32'h0000_0000);
        $display("test reset done");
        // All four modes; rates 0 to 5
        for (int m = 0; m < 6; m++) begin
            xfer({2'b00, 3'(m), 2'(m)}, 8'hC3 ^ 8'(m), 8'h5A + 8'(m));
            wait_idle();
            check("sck idle", sck_out, m[1]);
            check("target rx", t_rx, 8'hC3 ^ 8'(m));
            rdchk("done", SPX_OFF_STATUS, 32'h0000_0002);
            rdchk("rx", SPX_OFF_RX, 32'h0000_005A + 32'(m));
            rdchk("done clear", SPX_OFF_STATUS, 32'h0000_0000);
        end
        $display("test modes done");
        xfer(7'h00, 8'h81, 8'h3C);
        bus(1'b1, SPX_OFF_TX, 32'h0000_007E);
        wait_idle();
        check("reject", st_acc[SPX_STAT_REJECT], 1'b1);
        check("first kept", t_rx, 8'h81);
        xfer(7'h01, 8'h42, 8'h24);
        wait_idle();
        check("overrun", st_acc[SPX_STAT_OVER], 1'b1);
        rdchk("over clear", SPX_OFF_STATUS, 32'h0000_0002);
        rdchk("rx last", SPX_OFF_RX, 32'h0000_0024);
        $display("test errors done");
        xfer(7'h23, 8'h96, 8'h69);
        wait_idle();
        check("held", ss_n_out, 1'b0);
        rdchk("rx hold", SPX_OFF_RX, 32'h0000_0069);
        xfer(7'h23, 8'h17, 8'hE8);
        wait_idle();
        check("tgt hold", t_rx, 8'h17);
        rdchk("rx hold2", SPX_OFF_RX, 32'h0000_00E8);
        bus(1'b1, SPX_OFF_CTRL, 32'h0000_0003);
        rdchk("released", SPX_OFF_STATUS, 32'h0000_0000);
        check("ss high", ss_n_out, 1'b1);
        xfer(7'h40, 8'hFF, 8'hB1);
        wait_idle();
        rdchk("rx only", SPX_OFF_RX, 32'h0000_00B1);
        $display("test hold done");
        close_out();
    end
endmodule
`default_nettype wire
